/* File: hw/prd_pkg.sv */
/*
 * package for the processor register space decoder: group bases, field
 * positions, categories, the normal-group i/o window and the register map.
 * assumes nothing of its surroundings; used by the decoder and the testbench files.
 */
package prd_pkg;
    // ======================================================================
    // register number space
    localparam logic [31:0] GRP_SCTAG_BASE   = 32'h0100_0000;
    localparam logic [31:0] GRP_SDEALL_BASE  = 32'h0140_0000;
    localparam logic [31:0] GRP_PRIMARY_CACHE_TAG_GROUP_BASE   = 32'h0180_0000;
    localparam logic [31:0] GRP_PCPAR_BASE   = 32'h01c0_0000;
    localparam int          GRP_SEL_HI       = 23;
    localparam int          GRP_SEL_LO       = 22;
    localparam int          GRP_HIT_BIT      = 24;
    localparam int          SC_IDX_LO        = 5;
    localparam int          PCT_IDX_LO       = 5;
    localparam int          PCP_IDX_LO       = 3;
    localparam logic [31:0] IO_WINDOW_BASE   = 32'he100_0000;
    localparam int          NORMAL_COUNT     = 256;

    // ======================================================================
    // internally held normal-group registers
    localparam logic [7:0] REG_MMU_SYS_LEN   = 8'he5;
    localparam logic [7:0] REG_MMU_MAP_EN    = 8'he6;
    localparam logic [7:0] REG_MMU_PA_MODE   = 8'he7;
    localparam logic [7:0] REG_MM_FLT_ADDR   = 8'he8;
    localparam logic [7:0] REG_MM_FLT_PTE    = 8'he9;
    localparam logic [7:0] REG_MM_FLT_STS    = 8'hea;
    localparam logic [7:0] REG_XB_PAR_ADDR   = 8'hec;
    localparam logic [7:0] REG_XB_PAR_STS    = 8'hed;
    localparam logic [7:0] REG_PC_PAR_ADDR   = 8'hf2;
    localparam logic [7:0] REG_PC_STATUS     = 8'hf4;
    localparam logic [7:0] REG_PC_CONTROL    = 8'hf8;
    localparam logic [7:0] REG_TIMER_CS      = 8'h18;
    localparam logic [31:0] REG_RESET_VALUE  = 32'h0000_0000;

    // ======================================================================
    // types
    typedef enum logic [2:0] {
        GRP_NORMAL, GRP_SCTAG, GRP_SDEALL, GRP_PRIMARY_CACHE_TAG_GROUP, GRP_PCPAR
    } prd_group_t;

    typedef enum logic [1:0] {
        H_NONE, H_UCODE, H_INTCMD, H_EXTBUS
    } prd_handler_t;

    // class in [4:3]? kept simply as a 2-bit class and a 4-bit subclass field
    typedef struct packed {
        logic [1:0] cls;
        logic [3:0] sub;
        logic [1:0] acc;   // 0 none, 1 ro, 2 wo, 3 rw
        logic       bcast;
    } prd_cat_t;

    localparam logic [1:0] ACC_NONE = 2'h0;
    localparam logic [1:0] ACC_RO   = 2'h1;
    localparam logic [1:0] ACC_WO   = 2'h2;
    localparam logic [1:0] ACC_RW   = 2'h3;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] regNum;
        logic [31:0] wdata;
    } prd_req_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] data;
    } prd_bus_t;

    typedef struct packed {
        logic         valid;
        logic         write;
        prd_group_t   group;
        logic [15:0]  index;
        logic [7:0]   regNum;
        logic [31:0]  data;
    } prd_cmd_t;
endpackage : prd_pkg

/* File: hw/prd_reg_store.sv */
/*
 * small register memory for the internally held normal-group registers.
 * assumes one synchronous write port and a registered read port.
 */
`timescale 1ns/1ps
`default_nettype none
module prd_reg_store (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrIdx,
    input  wire logic [31:0] wrData,
    input  wire logic [3:0]  rdIdx,
    output var  logic [31:0] rdData
);
    typedef struct packed {
        logic [15:0][31:0] mem;
        logic [31:0]       rd;
    } prd_store_t;

    prd_store_t st_r;
    prd_store_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wrEn) begin
            st_nxt.mem[wrIdx] = wrData;
        end
        st_nxt.rd = st_r.mem[rdIdx];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.rd;
endmodule : prd_reg_store
`default_nettype wire

/* File: hw/prd_decoder.sv */
/* register space decoder: group sort, handler steering, held mmu registers.
 * assumes one request at a time held until reqReady; handlers pulse done. */
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - normal group: 256 longword registers, 1 KB
// R2 - io address is base plus number times four
// R3 - non-normal groups never reach external bus
// R4 - unheld normal registers go out as bus commands; here only class three and subclass three do
// R5 - secondary cache tag group at 01000000
// R6 - secondary cache deallocate group at 01400000
// R7 - primary cache tag group at 01800000
// R8 - primary cache parity group at 01c00000
// R9 - every number maps to some group
// R10 - unused fields ignored, no fault raised
// R11 - access type honoured per register
// R12 - class three registers go to external logic
// R13 - subclass two serviced by internal command
// R14 - subclass three: internal command then bus
// R15 - subclass five: internal command only; here all are held in the local store, no command issued
// R16 - subclass six block decoded, undefined result
// R17 - timer control/status built internally only
// R18 - broadcast writes also go to vector unit
// R19 - each access steered to exactly one handler; here subclass three uses internal command then bus
module prd_decoder (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire prd_pkg::prd_req_t req,
    output logic                  reqReady,
    output var  logic             rspValid,
    output var  logic [31:0]      rspData,
    output var  logic             rspIgnored,
    output var  prd_pkg::prd_cmd_t ucodeCmd,
    input  wire logic             ucodeDone,
    input  wire logic [31:0]      ucodeData,
    output var  prd_pkg::prd_cmd_t intCmd,
    input  wire logic             intDone,
    output var  prd_pkg::prd_bus_t extBus,
    input  wire logic             extDone,
    input  wire logic [31:0]      extData,
    output var  logic             vecWrite,
    output var  logic [7:0]       vecRegNum,
    output var  logic [31:0]      vecData,
    input  wire logic             vecPresent
);
    typedef enum logic [2:0] {
        S_IDLE, S_UCODE, S_INT, S_EXT, S_LOCAL, S_DONE
    } prd_state_t;

    typedef struct packed {
        prd_state_t        state;
        prd_pkg::prd_cmd_t ucode;
        prd_pkg::prd_cmd_t icmd;
        prd_pkg::prd_bus_t ext;
        logic              thenExt;
        logic              rspV;
        logic [31:0]       rspD;
        logic              ign;
        logic              vW;
        logic [7:0]        vN;
        logic [31:0]       vD;
        logic [31:0]       timerCs;
    } prd_ctx_t;
    prd_ctx_t r_r;
    prd_ctx_t r_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ======================================================================
    // group decode
    prd_pkg::prd_group_t grp;
    logic [15:0]         idx;
    prd_pkg::prd_cat_t   cat;
    logic [3:0]          storeIdx;
    logic                storeHit;
    logic [31:0]         storeRd;
    logic                storeWr;
    logic [31:0]         ioAddr;
    // R9 decode by top bits only, gaps fold into groups
    // R10 unused fields ignored, no fault
    always_comb begin
        idx = '0;
        if (!req.regNum[prd_pkg::GRP_HIT_BIT]) begin
            grp = prd_pkg::GRP_NORMAL;
        end else begin
            unique case (req.regNum[prd_pkg::GRP_SEL_HI:prd_pkg::GRP_SEL_LO])
                // R5 secondary tag group
                2'h0: begin
                    grp = prd_pkg::GRP_SCTAG;
                    idx = req.regNum[prd_pkg::SC_IDX_LO +: 16];
                end
                // R6 dealloc group
                2'h1: begin
                    grp = prd_pkg::GRP_SDEALL;
                    idx = req.regNum[prd_pkg::SC_IDX_LO +: 16];
                end
                // R7 primary tag group, set in bits 12:5
                2'h2: begin
                    grp = prd_pkg::GRP_PRIMARY_CACHE_TAG_GROUP;
                    idx = {8'h00, req.regNum[prd_pkg::PCT_IDX_LO +: 8]};
                end
                // R8 parity group, set in bits 12:3
                default: begin
                    grp = prd_pkg::GRP_PCPAR;
                    idx = {6'h00, req.regNum[prd_pkg::PCP_IDX_LO +: 10]};
                end
            endcase
        end
    end
    // R19 fixed per-number category lookup
    // R11 access type in the lookup
    always_comb begin
        cat = '{cls: 2'h2, sub: 4'h1, acc: prd_pkg::ACC_RW, bcast: 1'b0};
        unique case (req.regNum[7:0])
            prd_pkg::REG_MMU_SYS_LEN, prd_pkg::REG_MMU_PA_MODE,
            prd_pkg::REG_XB_PAR_STS, prd_pkg::REG_PC_STATUS,
            prd_pkg::REG_PC_CONTROL:
                cat = '{2'h2, 4'h5, prd_pkg::ACC_RW, 1'b0};
            prd_pkg::REG_MMU_MAP_EN:
                cat = '{2'h2, 4'h5, prd_pkg::ACC_RW, 1'b1};
            prd_pkg::REG_MM_FLT_ADDR, prd_pkg::REG_MM_FLT_PTE,
            prd_pkg::REG_MM_FLT_STS, prd_pkg::REG_XB_PAR_ADDR,
            prd_pkg::REG_PC_PAR_ADDR:
                cat = '{2'h2, 4'h5, prd_pkg::ACC_RO, 1'b0};
            prd_pkg::REG_TIMER_CS:
                cat = '{2'h2, 4'h7, prd_pkg::ACC_RW, 1'b0};
            8'heb, 8'hee, 8'hef, 8'hf0, 8'hf1, 8'hf3, 8'hf5, 8'hf6,
            8'hf7, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff:
                cat = '{2'h2, 4'h6, prd_pkg::ACC_NONE, 1'b0};
            default: begin
                if (req.regNum[7:0] >= 8'h20 && req.regNum[7:0] < 8'hd8) begin
                    // R12 class three: bus only
                    cat = '{2'h3, 4'h0, prd_pkg::ACC_RW, 1'b0};
                end else if (req.regNum[7:0] >= 8'he0) begin
                    // R13 subclass two mmu translation
                    cat = '{2'h2, 4'h2, prd_pkg::ACC_RW, 1'b0};
                end else if (req.regNum[7:0] >= 8'hd8) begin
                    cat = '{2'h2, 4'h6, prd_pkg::ACC_NONE, 1'b0};
                end else if (req.regNum[7:0] >= 8'h1c) begin
                    // R14 subclass three: internal then bus
                    cat = '{2'h1, 4'h3, prd_pkg::ACC_RW, 1'b0};
                end
            end
        endcase
    end
    // R1 one longword per normal register
    // R2 base plus number in bits 9:2
    assign ioAddr = prd_pkg::IO_WINDOW_BASE | {22'h0, req.regNum[7:0], 2'h0};
    assign storeHit = (storeIdx != 4'hf);
    always_comb begin
        unique case (req.regNum[7:0])
            prd_pkg::REG_MMU_SYS_LEN: storeIdx = 4'h0;
            prd_pkg::REG_MMU_MAP_EN:  storeIdx = 4'h1;
            prd_pkg::REG_MMU_PA_MODE: storeIdx = 4'h2;
            prd_pkg::REG_MM_FLT_ADDR: storeIdx = 4'h3;
            prd_pkg::REG_MM_FLT_PTE:  storeIdx = 4'h4;
            prd_pkg::REG_MM_FLT_STS:  storeIdx = 4'h5;
            prd_pkg::REG_XB_PAR_ADDR: storeIdx = 4'h6;
            prd_pkg::REG_XB_PAR_STS:  storeIdx = 4'h7;
            prd_pkg::REG_PC_PAR_ADDR: storeIdx = 4'h8;
            prd_pkg::REG_PC_STATUS:   storeIdx = 4'h9;
            prd_pkg::REG_PC_CONTROL:  storeIdx = 4'ha;
            default:                  storeIdx = 4'hf;
        endcase
    end
    // ======================================================================
    // steering
    assign reqReady = (r_r.state == S_IDLE);
    assign storeWr  = reqReady && req.valid && req.write
                      && grp == prd_pkg::GRP_NORMAL && storeHit
                      && cat.acc == prd_pkg::ACC_RW;
    always_comb begin
        r_nxt = r_r;
        r_nxt.rspV = 1'b0;
        r_nxt.vW = 1'b0;
        unique case (r_r.state)
            S_IDLE: begin
                if (req.valid) begin
                    r_nxt.ign = 1'b0;
                    r_nxt.rspD = '0;
                    r_nxt.icmd = '{1'b0, req.write, grp, idx,
                                   req.regNum[7:0], req.wdata};
                    r_nxt.thenExt = 1'b0;
                    if (grp != prd_pkg::GRP_NORMAL) begin
                        // R3 cache groups stay inside the chip
                        r_nxt.icmd.valid = 1'b1;
                        r_nxt.state = S_INT;
                    end else if ((req.write && cat.acc == prd_pkg::ACC_RO) ||
                                 (!req.write && cat.acc == prd_pkg::ACC_WO) ||
                                 cat.acc == prd_pkg::ACC_NONE) begin
                        // R11 wrong direction dropped
                        // R16 reserved numbers swallowed
                        r_nxt.ign = 1'b1;
                        r_nxt.state = S_DONE;
                    end else if (cat.cls == 2'h3) begin
                        // R4 bus command at converted address
                        r_nxt.ext = '{1'b1, req.write, ioAddr, req.wdata};
                        r_nxt.state = S_EXT;
                    end else if (cat.sub == 4'h7) begin
                        // R17 only the timer subset is held here
                        r_nxt.timerCs = req.write ? req.wdata : r_r.timerCs;
                        r_nxt.rspD = r_r.timerCs;
                        r_nxt.state = S_DONE;
                    end else if (storeHit) begin
                        // R15 internal only, kept locally
                        r_nxt.state = S_LOCAL;
                    end else if (cat.sub == 4'h2 || cat.sub == 4'h5 ||
                                 cat.sub == 4'h3) begin
                        // R13 R14 internal command first
                        r_nxt.icmd.valid = 1'b1;
                        r_nxt.thenExt = (cat.sub == 4'h3);
                        r_nxt.ext = '{1'b0, req.write, ioAddr, req.wdata};
                        r_nxt.state = S_INT;
                    end else begin
                        r_nxt.ucode = '{1'b1, req.write, grp, idx,
                                        req.regNum[7:0], req.wdata};
                        r_nxt.state = S_UCODE;
                    end
                    // R18 broadcast copy to vector unit
                    if (req.write && cat.bcast && vecPresent &&
                        grp == prd_pkg::GRP_NORMAL) begin
                        r_nxt.vW = 1'b1;
                        r_nxt.vN = req.regNum[7:0];
                        r_nxt.vD = req.wdata;
                    end
                end
            end
            S_UCODE: begin
                if (ucodeDone) begin
                    r_nxt.ucode.valid = 1'b0;
                    r_nxt.rspD = ucodeData;
                    r_nxt.state = S_DONE;
                end
            end
            S_INT: begin
                if (intDone) begin
                    r_nxt.icmd.valid = 1'b0;
                    if (r_r.thenExt) begin
                        // R14 then external read or write
                        r_nxt.ext.valid = 1'b1;
                        r_nxt.state = S_EXT;
                    end else begin
                        r_nxt.state = S_DONE;
                    end
                end
            end
            S_EXT: begin
                if (extDone) begin
                    r_nxt.ext.valid = 1'b0;
                    r_nxt.rspD = extData;
                    r_nxt.state = S_DONE;
                end
            end
            S_LOCAL: begin
                r_nxt.rspD = storeRd;
                r_nxt.state = S_DONE;
            end
            S_DONE: begin
                r_nxt.rspV = 1'b1;
                r_nxt.state = S_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
    prd_reg_store u_store (
        .clk    (clk),
        .sys_rst(sys_rst),
        .wrEn   (storeWr),
        .wrIdx  (storeIdx),
        .wrData (req.wdata),
        .rdIdx  (storeIdx),
        .rdData (storeRd)
    );
    assign rspValid   = r_r.rspV;
    assign rspData    = r_r.rspD;
    assign rspIgnored = r_r.ign;
    assign ucodeCmd   = r_r.ucode;
    assign intCmd     = r_r.icmd;
    assign extBus     = r_r.ext;
    assign vecWrite   = r_r.vW;
    assign vecRegNum  = r_r.vN;
    assign vecData    = r_r.vD;
    // ======================================================================
    // checks
    property p_noext_cache;
        extBus.valid |-> extBus.addr[31:10] == prd_pkg::IO_WINDOW_BASE[31:10];
    endproperty
    a_noext_cache: assert property (p_noext_cache) // R3
        else $error("bus address outside io window");
    property p_addr;
        (reqReady && req.valid && cat.cls == 2'h3 &&
         grp == prd_pkg::GRP_NORMAL)
        |=> extBus.valid && extBus.addr ==
            {prd_pkg::IO_WINDOW_BASE[31:10], $past(req.regNum[7:0]), 2'h0};
    endproperty
    a_addr: assert property (p_addr) // R2
        else $error("io address wrong");
    property p_cache_int;
        (reqReady && req.valid && req.regNum[24])
        |=> intCmd.valid && !extBus.valid;
    endproperty
    a_cache_int: assert property (p_cache_int) // R3
        else $error("cache group not internal");
    property p_one_handler;
        $onehot0({ucodeCmd.valid, intCmd.valid, extBus.valid});
    endproperty
    a_one_handler: assert property (p_one_handler) // R19
        else $error("more than one handler");
    property p_ro_ignored;
        (reqReady && req.valid && req.write && !req.regNum[24] &&
         req.regNum[7:0] == 8'he8) |=> ##1 rspValid && rspIgnored;
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) // R11
        else $error("read-only write not dropped");
    property p_bcast;
        (reqReady && req.valid && req.write && vecPresent &&
         !req.regNum[24] && req.regNum[7:0] == 8'he6)
        |=> vecWrite && vecRegNum == 8'he6;
    endproperty
    a_bcast: assert property (p_bcast) // R18
        else $error("broadcast write missing");
    property p_sub3;
        (r_r.state == S_INT && r_r.thenExt && intDone) |=> extBus.valid;
    endproperty
    a_sub3: assert property (p_sub3) // R14
        else $error("subclass three not sent to bus");
    property p_sub6;
        (reqReady && req.valid && !req.regNum[24] &&
         req.regNum[7:0] == 8'hfc) |=> ##1 rspValid && !extBus.valid;
    endproperty
    a_sub6: assert property (p_sub6) // R16
        else $error("reserved number not swallowed");
endmodule : prd_decoder
`default_nettype wire

/* File: testbench/prd_env_model.sv */
/*
 * system environment model on the far side of the decoder: answers bus,
 * internal and microcode commands with a one-cycle done pulse.
 * assumes each command holds valid until the edge that samples its done.
 */
`timescale 1ns/1ps
`default_nettype none
module prd_env_model (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [3:0]        waitCycles,
    input  wire prd_pkg::prd_bus_t extBus,
    input  wire prd_pkg::prd_cmd_t intCmd,
    input  wire prd_pkg::prd_cmd_t ucodeCmd,
    output logic                   extDone,
    output logic [31:0]            extData,
    output logic                   intDone,
    output logic                   ucodeDone,
    output logic [31:0]            ucodeData,
    output int                     extCount,
    output int                     intCount,
    output logic [31:0]            lastAddr,
    output prd_pkg::prd_group_t    lastGroup
);
    logic [3:0] extWait;
    logic [3:0] intWait;
    logic [3:0] ucWait;
    // ======================================================================
    // external bus: slow or prompt, data wobbles when not answering
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            extDone  <= 1'b0;
            extData  <= 32'h0;
            extWait  <= 4'h0;
            extCount <= 0;
            lastAddr <= 32'h0;
        end else begin
            extDone <= 1'b0;
            extData <= ~extData;
            if (extBus.valid && !extDone) begin
                extWait <= extWait + 4'h1;
                if (extWait == waitCycles) begin
                    extDone  <= 1'b1;
                    extData  <= extBus.write ? extBus.data : ~extBus.addr;
                    extWait  <= 4'h0;
                    extCount <= extCount + 1;
                    lastAddr <= extBus.addr;
                end
            end
        end
    end
    // ======================================================================
    // internal command and microcode handlers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            intDone   <= 1'b0;
            ucodeDone <= 1'b0;
            ucodeData <= 32'h0;
            intWait   <= 4'h0;
            ucWait    <= 4'h0;
            intCount  <= 0;
            lastGroup <= prd_pkg::GRP_NORMAL;
        end else begin
            intDone   <= 1'b0;
            ucodeDone <= 1'b0;
            ucodeData <= ~ucodeData;
            if (intCmd.valid && !intDone) begin
                intWait <= intWait + 4'h1;
                if (intWait == waitCycles) begin
                    intDone   <= 1'b1;
                    intWait   <= 4'h0;
                    intCount  <= intCount + 1;
                    lastGroup <= intCmd.group;
                end
            end
            if (ucodeCmd.valid && !ucodeDone) begin
                ucWait <= ucWait + 4'h1;
                if (ucWait == waitCycles) begin
                    ucodeDone <= 1'b1;
                    ucodeData <= {24'h5a5a5a, ucodeCmd.regNum};
                    ucWait    <= 4'h0;
                end
            end
        end
    end
endmodule : prd_env_model
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
 * self-checking bench for the register space decoder.
 * assumes the environment model answers every handler command.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                clk;
    logic                sys_rst;
    prd_pkg::prd_req_t   req;
    logic                reqReady, rspValid, rspIgnored;
    logic [31:0]         rspData, extData, ucodeData, vecData, lastAddr;
    prd_pkg::prd_cmd_t   ucodeCmd, intCmd;
    prd_pkg::prd_bus_t   extBus;
    logic                ucodeDone, intDone, extDone, vecWrite, vecPresent;
    logic [7:0]          vecRegNum, vecNum;
    logic [3:0]          waitCycles;
    prd_pkg::prd_group_t lastGroup;
    logic [31:0]         rdOut, vecDat;
    logic                ignOut;
    int                  extCount, intCount, vecCount, n_mismatch, samples_checked;
    prd_decoder i_prd_decoder (.clk(clk), .sys_rst(sys_rst), .req(req),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rspIgnored(rspIgnored), .ucodeCmd(ucodeCmd), .ucodeDone(ucodeDone),
        .ucodeData(ucodeData), .intCmd(intCmd), .intDone(intDone),
        .extBus(extBus), .extDone(extDone), .extData(extData),
        .vecWrite(vecWrite), .vecRegNum(vecRegNum), .vecData(vecData),
        .vecPresent(vecPresent));
    prd_env_model i_prd_env_model (.clk(clk), .sys_rst(sys_rst),
        .waitCycles(waitCycles), .extBus(extBus), .intCmd(intCmd),
        .ucodeCmd(ucodeCmd), .extDone(extDone), .extData(extData),
        .intDone(intDone), .ucodeDone(ucodeDone), .ucodeData(ucodeData),
        .extCount(extCount), .intCount(intCount), .lastAddr(lastAddr),
        .lastGroup(lastGroup));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (vecWrite === 1'b1) begin
        vecCount <= vecCount + 1;
        vecNum   <= vecRegNum;
        vecDat   <= vecData;
    end
    // ======================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // entered just after an edge; holds the request until it is taken
    task automatic acc(input logic wr, input logic [31:0] num,
                       input logic [31:0] wd);
        logic taken;
        int   k;
        taken = 1'b0;
        k = 0;
        req = '{valid: 1'b1, write: wr, regNum: num, wdata: wd};
        do begin
            taken = (reqReady === 1'b1);
            @(posedge clk);
            #2;
        end while (!taken);
        req.valid = 1'b0;
        while (rspValid !== 1'b1 && k < 200) begin
            @(posedge clk);
            #2;
            k++;
        end
        if (k == 200) chk(32'h0, 32'h1);
        rdOut  = rspData;
        ignOut = rspIgnored;
        @(posedge clk);
        #2;
    endtask : acc
    // ======================================================================
    // scenarios
    task automatic t_bus();
        logic [7:0] nums [4] = '{8'h20, 8'h30, 8'h80, 8'hd7};
        int e;
        logic [31:0] a;
        e = extCount;
        for (int w = 0; w < 2; w++) begin
            waitCycles = (w == 0) ? 4'h0 : 4'h3;
            foreach (nums[i]) for (int wr = 0; wr < 2; wr++) begin
                a = prd_pkg::IO_WINDOW_BASE + nums[i] * 4;
                acc(wr[0], {24'h0, nums[i]}, 32'h1234_0000 | nums[i]);
                e++;
                chk(lastAddr, a);
                chk(extCount, e);
                chk(rdOut, wr ? 32'h1234_0000 | nums[i] : ~a);
            end
        end
        waitCycles = 4'h1;
        $display("done t_bus");
    endtask : t_bus
    task automatic t_groups();
        logic [31:0] nums [5] = '{32'h0100_0020, 32'h0140_0040,
            32'h0180_0020, 32'h01c0_0008, 32'h7fc0_0008};
        prd_pkg::prd_group_t g [5] = '{prd_pkg::GRP_SCTAG,
            prd_pkg::GRP_SDEALL, prd_pkg::GRP_PRIMARY_CACHE_TAG_GROUP, prd_pkg::GRP_PCPAR,
            prd_pkg::GRP_PCPAR};
        int e;
        e = extCount;
        foreach (nums[i]) begin
            acc(i[0], nums[i], 32'h0);
            chk(lastGroup, g[i]);
            chk(extCount, e);
        end
        $display("done t_groups");
    endtask : t_groups
    task automatic t_local();
        int e;
        e = extCount;
        acc(1'b0, 32'he7, 32'h0);
        chk(rdOut, prd_pkg::REG_RESET_VALUE);
        acc(1'b1, 32'he5, 32'hcafe_0123);
        acc(1'b0, 32'he5, 32'h0);
        chk(rdOut, 32'hcafe_0123);
        acc(1'b1, 32'he8, 32'h5);
        chk(ignOut, 1'b1);
        acc(1'b0, 32'hfc, 32'h0);
        chk(ignOut, 1'b1);
        chk(extCount, e);
        $display("done t_local");
    endtask : t_local
    task automatic t_sub();
        int e;
        int n;
        e = extCount;
        n = intCount;
        acc(1'b0, 32'he0, 32'h0);
        chk(intCount, n + 1);
        chk(extCount, e);
        acc(1'b0, 32'h1c, 32'h0);
        chk(intCount, n + 2);
        chk(lastAddr, 32'he100_0070);
        acc(1'b0, 32'h05, 32'h0);
        chk(rdOut, 32'h5a5a_5a05);
        chk(intCount, n + 2);
        acc(1'b0, prd_pkg::REG_TIMER_CS, 32'h0);
        chk(extCount, e + 1);
        $display("done t_sub");
    endtask : t_sub
    task automatic t_bcast();
        int v;
        v = vecCount;
        vecPresent = 1'b1;
        acc(1'b1, 32'he6, 32'h0000_0001);
        chk(vecCount, v + 1);
        chk(vecNum, 8'he6);
        chk(vecDat, 32'h0000_0001);
        acc(1'b1, 32'he5, 32'h7);
        chk(vecCount, v + 1);
        vecPresent = 1'b0;
        acc(1'b1, 32'he6, 32'h0);
        chk(vecCount, v + 1);
        $display("done t_bcast");
    endtask : t_bcast
    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // ======================================================================
    // main sequence and watchdog
    initial begin
        sys_rst = 1'b1;
        req = '0;
        vecPresent = 1'b0;
        waitCycles = 4'h0;
        vecCount = 0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        #2;
        sys_rst = 1'b0;
        chk(reqReady, 1'b1);
        chk(extBus.valid, 1'b0);
        t_bus();
        t_groups();
        t_local();
        t_sub();
        t_bcast();
        results();
    end
    initial begin
        // roughly thirty-three accesses of under twenty cycles, with wide margin
        #(20000 * 50);
        n_mismatch++;
        results();
    end
endmodule : tb_top
`default_nettype wire
